// ===== src/rnpc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rnpc_map.svh"
module rnpc_top
    import rnpc_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    // Reset pin, open drain
    input  wire logic       EXT_RESET_IN_I,
    output logic            EXT_RESET_IN_O,
    output logic            EXT_RESET_IN_OE,
    output logic            RESET_INDICATION_OUT,
    // Interrupt and timing pins
    input  wire logic       NMI_N,
    input  wire logic       POWERDOWN_RETURN_TIMING_PIN,
    // CPU side
    input  wire rnpc_cpu_s  CPU,
    input  wire logic       BIDIR_RESET_ENABLE,
    input  wire logic       POWERDOWN_CONFIG_BIT,
    output logic            CORE_RESET,
    output logic            NMI_TRAP,
    output logic            POWERDOWN_MODE,
    output logic            ASYNC_RESET_SEL
);
    ////////////////////////////////////////////////////////////////////////
    // Raw and synchronised pin levels
    logic                          rst_s;
    logic                          nmi_s;
    logic                          rpd_s;
    logic [`RNPC_PIN_NUM-1:0]      pin_raw;
    wire logic [`RNPC_PIN_NUM-1:0] pin_s;
    // Edge memory, filter and sequence state
    logic                          nmi_prev_q;
    logic [`RNPC_CNT_W-1:0]        low_q;
    logic [`RNPC_CNT_W-1:0]        seq_q;
    rnpc_state_e                   st_q;
    // Reset sources
    logic                          hw_rst;
    logic                          any_rst;
    genvar                         gi;

    ////////////////////////////////////////////////////////////////////////
    // Shared state decodes
    function automatic logic in_seq(input rnpc_state_e st);
        return st == RNPC_SEQ;
    endfunction : in_seq

    // Indication only rises once the CPU has left initialisation
    function automatic logic released(input rnpc_state_e st);
        return st == RNPC_RUN || st == RNPC_PWD;
    endfunction : released

    ////////////////////////////////////////////////////////////////////////
    // Pins are asynchronous to CLK; bit order follows the pin indices
    assign pin_raw = {POWERDOWN_RETURN_TIMING_PIN, NMI_N, EXT_RESET_IN_I};

    generate
        for (gi = 0; gi < `RNPC_PIN_NUM; gi = gi + 1)
        begin : g_sync
            rnpc_sync u_sync
            (
                .clk    (CLK),
                .arst_n (ARST_N),
                .din    (pin_raw[gi]),
                .dout   (pin_s[gi])
            );
        end
    endgenerate

    assign rst_s = pin_s[`RNPC_PIN_RST];
    assign nmi_s = pin_s[`RNPC_PIN_NMI];
    assign rpd_s = pin_s[`RNPC_PIN_RPD];

    ////////////////////////////////////////////////////////////////////////
    // Low-time filter; our own drive is masked so it cannot retrigger
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            low_q <= `RNPC_CNT_ZERO;
        else if (rst_s || EXT_RESET_IN_OE)
            low_q <= `RNPC_CNT_ZERO;
        else if (low_q != `RNPC_CNT_W'(`RNPC_MIN_LOW_CYC))
            low_q <= low_q + `RNPC_CNT_ONE;
    end
    assign hw_rst = (low_q == `RNPC_CNT_W'(`RNPC_MIN_LOW_CYC - 1))
                    && !rst_s && !EXT_RESET_IN_OE;
    assign any_rst = hw_rst || CPU.sw_reset || CPU.wdt_reset;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            st_q  <= RNPC_SEQ;
            seq_q <= `RNPC_CNT_ZERO;
        end
        else if (any_rst)
        begin
            st_q  <= RNPC_SEQ;
            seq_q <= `RNPC_CNT_ZERO;
        end
        else
        begin
            case (st_q)
                RNPC_SEQ:
                begin
                    if (seq_q == `RNPC_CNT_W'(`RNPC_SEQ_CYC - 1))
                        st_q <= RNPC_INIT;
                    else
                        seq_q <= seq_q + `RNPC_CNT_ONE;
                end
                RNPC_INIT:
                    if (CPU.end_of_init_instruction)
                        st_q <= RNPC_RUN;
                RNPC_RUN:
                    // Bit set: mode not gated by the interrupt pin
                    if (CPU.powerdown_instruction
                        && (POWERDOWN_CONFIG_BIT || !nmi_s))
                        st_q <= RNPC_PWD;
                RNPC_PWD:
                    // Wake on timing pin high; interrupt low unless bit set
                    if (rpd_s && (!nmi_s || POWERDOWN_CONFIG_BIT))
                        st_q <= RNPC_RUN;
                default:
                    st_q <= RNPC_SEQ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            CORE_RESET           <= 1'h1;
            RESET_INDICATION_OUT <= 1'h0;
            EXT_RESET_IN_O       <= 1'h0;
            EXT_RESET_IN_OE      <= 1'h0;
            POWERDOWN_MODE       <= 1'h0;
            ASYNC_RESET_SEL      <= 1'h0;
        end
        else
        begin
            CORE_RESET           <= any_rst || in_seq(st_q);
            RESET_INDICATION_OUT <= !any_rst && released(st_q);
            EXT_RESET_IN_O       <= 1'h0;
            EXT_RESET_IN_OE      <= BIDIR_RESET_ENABLE
                                    && in_seq(st_q) && !any_rst;
            POWERDOWN_MODE       <= (st_q == RNPC_PWD);
            // Low level on timing pin selects asynchronous reset
            ASYNC_RESET_SEL      <= !rpd_s;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            nmi_prev_q <= 1'h1;
            NMI_TRAP   <= 1'h0;
        end
        else
        begin
            nmi_prev_q <= nmi_s;
            NMI_TRAP   <= nmi_prev_q && !nmi_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_nmi_trap_edge: assert property (@(posedge CLK)
        disable iff (!ARST_N) $fell(nmi_s) |=> NMI_TRAP)
        else $error("trap missing after falling edge");
    a_trap_pulse: assert property (@(posedge CLK)
        disable iff (!ARST_N) NMI_TRAP |=> !NMI_TRAP)
        else $error("trap longer than one cycle");
    a_pwd_blocked: assert property (@(posedge CLK)
        disable iff (!ARST_N)
        (st_q == RNPC_RUN && CPU.powerdown_instruction && nmi_s
         && !POWERDOWN_CONFIG_BIT && !any_rst) |=> st_q == RNPC_RUN)
        else $error("power-down taken with interrupt pin high");
    a_pwd_taken: assert property (@(posedge CLK)
        disable iff (!ARST_N)
        (st_q == RNPC_RUN && CPU.powerdown_instruction && !nmi_s
         && !any_rst) |=> ##1 POWERDOWN_MODE)
        else $error("power-down not entered");
    a_pwd_wake: assert property (@(posedge CLK)
        disable iff (!ARST_N)
        (st_q == RNPC_PWD && rpd_s && (!nmi_s || POWERDOWN_CONFIG_BIT)
         && !any_rst) |=> st_q == RNPC_RUN)
        else $error("no return from power-down");
    a_async_sel: assert property (@(posedge CLK)
        disable iff (!ARST_N) !rpd_s |=> ASYNC_RESET_SEL)
        else $error("reset selection does not follow timing pin");
    a_reset_indication_out_low: assert property (@(posedge CLK)
        disable iff (!ARST_N)
        (any_rst || in_seq(st_q)) |=> !RESET_INDICATION_OUT)
        else $error("indication high during reset");
    a_reset_indication_out_end_of_init_instruction: assert property (@(posedge CLK)
        disable iff (!ARST_N)
        (st_q == RNPC_INIT && CPU.end_of_init_instruction && !any_rst)
        ##1 !any_rst |=> RESET_INDICATION_OUT)
        else $error("indication not released");
    a_bidir_drive: assert property (@(posedge CLK)
        disable iff (!ARST_N)
        EXT_RESET_IN_OE |-> BIDIR_RESET_ENABLE || $past(BIDIR_RESET_ENABLE))
        else $error("reset line driven without enable");
    a_drive_low: assert property (@(posedge CLK)
        disable iff (!ARST_N) EXT_RESET_IN_OE |-> !EXT_RESET_IN_O)
        else $error("reset line driven high");
    a_drive_idle: assert property (@(posedge CLK)
        disable iff (!ARST_N) !BIDIR_RESET_ENABLE |=> !EXT_RESET_IN_OE)
        else $error("reset line driven in plain reset mode");
    a_hw_reset: assert property (@(posedge CLK)
        disable iff (!ARST_N)
        hw_rst |=> in_seq(st_q) && seq_q == `RNPC_CNT_ZERO)
        else $error("filtered reset not taken");
    a_seq_len: assert property (@(posedge CLK)
        disable iff (!ARST_N)
        (in_seq(st_q) && !any_rst
         && seq_q == `RNPC_CNT_W'(`RNPC_SEQ_CYC - 1)) |=> st_q == RNPC_INIT)
        else $error("reset sequence length wrong");
endmodule : rnpc_top
`default_nettype wire

// ===== src/rnpc_map.svh
`ifndef RNPC_MAP_SVH
`define RNPC_MAP_SVH
`define RNPC_MIN_LOW_NS    64
`define RNPC_CLK_NS        8
`define RNPC_MIN_LOW_CYC   ((`RNPC_MIN_LOW_NS + `RNPC_CLK_NS - 1) / `RNPC_CLK_NS)
`define RNPC_SEQ_NS        1024
`define RNPC_SEQ_CYC       (`RNPC_SEQ_NS / `RNPC_CLK_NS)
`define RNPC_CNT_W         8
`define RNPC_CNT_ZERO      8'h00
`define RNPC_CNT_ONE       8'h01
`define RNPC_PIN_NUM       3
`define RNPC_PIN_RST       0
`define RNPC_PIN_NMI       1
`define RNPC_PIN_RPD       2
`endif

// ===== src/rnpc_pkg.sv
`default_nettype none
package rnpc_pkg;
    typedef enum logic [1:0] {
        RNPC_RUN  = 2'b00,
        RNPC_SEQ  = 2'b01,
        RNPC_INIT = 2'b10,
        RNPC_PWD  = 2'b11
    } rnpc_state_e;

    typedef struct packed {
        logic powerdown_instruction;
        logic end_of_init_instruction;
        logic sw_reset;
        logic wdt_reset;
    } rnpc_cpu_s;
endpackage : rnpc_pkg
`default_nettype wire

// ===== src/rnpc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rnpc_sync
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] s_q;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= 3'h7;
        else
            s_q <= {s_q[1:0], din};
    end
    // Change accepted once stages two and three agree
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            dout <= 1'h1;
        else if (s_q[1] == s_q[2])
            dout <= s_q[2];
    end
endmodule : rnpc_sync
`default_nettype wire

// ===== test/rnpc_board.sv
`timescale 1ns/1ps
`default_nettype none
module rnpc_board
(
    // Board control
    input  wire logic pull_low,
    // Device drive
    input  wire logic dev_o,
    input  wire logic dev_oe,
    // Resolved pin
    output logic      pin
);
    // Pull-up holds the line high unless a party sinks it
    assign pin = !(pull_low || (dev_oe && !dev_o));
endmodule : rnpc_board
`default_nettype wire

// ===== test/reset_nmi_powerdown_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module reset_nmi_powerdown_ctrl_tb_top;
    import rnpc_pkg::*;
    logic       clk = 0;
    logic       arst_n = 0;
    logic       pull = 0;
    logic       nmi_n = 1;
    logic       powerdown_return_timing_pin = 0;
    logic       bdr = 0;
    logic       cfg = 0;
    rnpc_cpu_s  cpu = '0;
    wire logic  pin;
    logic       ro, oe, ind, cr, trap, pwd, asel;
    int         err_total = 0;
    int         tests_run = 0;
    always #4 clk = !clk;
    rnpc_board u_board (.pull_low(pull), .dev_o(ro), .dev_oe(oe),
        .pin(pin));
    rnpc_top dut (.CLK(clk), .ARST_N(arst_n), .EXT_RESET_IN_I(pin),
        .EXT_RESET_IN_O(ro), .EXT_RESET_IN_OE(oe),
        .RESET_INDICATION_OUT(ind), .NMI_N(nmi_n),
        .POWERDOWN_RETURN_TIMING_PIN(powerdown_return_timing_pin), .CPU(cpu),
        .BIDIR_RESET_ENABLE(bdr), .POWERDOWN_CONFIG_BIT(cfg),
        .CORE_RESET(cr), .NMI_TRAP(trap), .POWERDOWN_MODE(pwd),
        .ASYNC_RESET_SEL(asel));
    ////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s exp %b got %b", nm, e, g);
        end
    endtask : chk
    function automatic logic obs(input int k);
        return k == 0 ? cr : k == 1 ? ind : k == 2 ? trap : pwd;
    endfunction : obs
    // Bounded poll; a miss ends the run
    task automatic wait_obs(input int k, input logic v, input int n,
        input string nm);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            if (obs(k) === v)
            begin
                chk(nm, v, obs(k));
                return;
            end
        end
        chk(nm, v, obs(k));
        give_verdict();
    endtask : wait_obs
    task automatic pulse(input logic [3:0] b);
        @(posedge clk) cpu <= rnpc_cpu_s'(b);
        @(posedge clk) cpu <= rnpc_cpu_s'(4'h0);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////
    task automatic t_boot;
        wait_obs(0, 1'b0, 300, "core_reset_end");
        chk("ind_held", 1'b0, ind);
        pulse(4'h4);
        wait_obs(1, 1'b1, 10, "ind_release");
    endtask : t_boot
    task automatic t_nmi;
        @(posedge clk) nmi_n <= 0;
        wait_obs(2, 1'b1, 12, "nmi_trap");
        @(posedge clk) nmi_n <= 1;
        #1;
        chk("nmi_pulse", 1'b0, trap);
        repeat (8) @(posedge clk);
    endtask : t_nmi
    task automatic t_pwd;
        pulse(4'h8);
        repeat (8) @(posedge clk);
        #1;
        chk("pwd_refused", 1'b0, pwd);
        chk("async_sel", 1'b1, asel);
        @(posedge clk) nmi_n <= 0;
        repeat (8) @(posedge clk);
        pulse(4'h8);
        wait_obs(3, 1'b1, 6, "pwd_taken");
        @(posedge clk) powerdown_return_timing_pin <= 1;
        wait_obs(3, 1'b0, 12, "pwd_wake");
        chk("sync_sel", 1'b0, asel);
        @(posedge clk) powerdown_return_timing_pin <= 0;
        nmi_n <= 1;
        repeat (8) @(posedge clk);
        // Bit set: interrupt pin high no longer blocks power-down
        @(posedge clk) cfg <= 1;
        pulse(4'h8);
        wait_obs(3, 1'b1, 6, "pwd_cfg_taken");
        @(posedge clk) powerdown_return_timing_pin <= 1;
        wait_obs(3, 1'b0, 12, "pwd_cfg_wake");
        @(posedge clk) powerdown_return_timing_pin <= 0;
        cfg <= 0;
        repeat (8) @(posedge clk);
    endtask : t_pwd
    task automatic t_plain;
        // Four cycles low is below the filter and must not reset
        @(posedge clk) pull <= 1;
        repeat (4) @(posedge clk);
        pull <= 0;
        repeat (12) @(posedge clk);
        #1;
        chk("glitch_core", 1'b0, cr);
        chk("glitch_ind", 1'b1, ind);
        @(posedge clk) pull <= 1;
        wait_obs(0, 1'b1, 20, "plain_reset");
        @(posedge clk) pull <= 0;
        repeat (2) @(posedge clk);
        #1;
        chk("plain_no_drive", 1'b0, oe);
        t_boot();
    endtask : t_plain
    task automatic t_pin;
        @(posedge clk) bdr <= 1;
        pull <= 1;
        wait_obs(0, 1'b1, 20, "pin_reset");
        @(posedge clk) pull <= 0;
        #1;
        chk("pin_drive", 1'b1, oe);
        chk("pin_level", 1'b0, ro);
        chk("ind_low", 1'b0, ind);
        t_boot();
        chk("pin_free", 1'b1, pin);
    endtask : t_pin
    task automatic t_soft(input logic [3:0] b);
        pulse(b);
        wait_obs(1, 1'b0, 10, "ind_soft");
        t_boot();
    endtask : t_soft
    initial
    begin
        repeat (2) @(posedge clk);
        arst_n <= 1;
        #1;
        chk("ind_reset", 1'b0, ind);
        t_boot();
        t_nmi();
        t_pwd();
        t_plain();
        t_pin();
        t_soft(4'h2);
        t_soft(4'h1);
        give_verdict();
    end
endmodule : reset_nmi_powerdown_ctrl_tb_top
`default_nettype wire
